// ==== hw/ext_csd_pkg.sv ====
package ext_csd_pkg;

    // ----------------------------------------------------------------
    // Field indices inside the configuration block
    // ----------------------------------------------------------------
    localparam int IDX_W = 9;
    localparam logic [IDX_W-1:0] IDX_PURGE = 9'h010;
    localparam logic [IDX_W-1:0] IDX_FEAT = 9'h011;
    localparam logic [IDX_W-1:0] IDX_NOTICE = 9'h022;
    localparam logic [IDX_W-1:0] IDX_PROD = 9'h085;
    localparam logic [IDX_W-1:0] IDX_SLEEP_T = 9'h0d8;

    // ----------------------------------------------------------------
    // Field layouts and fixed values
    // ----------------------------------------------------------------
    localparam int FEAT_MODE_BIT = 5;
    localparam int FEAT_EN_BIT = 4;
    localparam logic [1:0] FEAT_CAPS = 2'h1;       // Bit0 manual set, bit1 auto clear
    localparam int PURGE_SEL_LSB = 4;
    localparam logic [1:0] PURGE_VENDOR = 2'h3;
    localparam logic [3:0] PURGE_CAPS = 4'h8;      // Only the vendor method
    localparam logic [7:0] SLEEP_TIME_CODE = 8'h0e;
    localparam logic [7:0] NOTICE_RESET = 8'h00;
    localparam logic [7:0] NOTICE_POWER_OFF_LONG = 8'h03;
    localparam logic [7:0] NOTICE_SLEEP = 8'h04;
    localparam logic [7:0] PROD_NORMAL = 8'h00;
    localparam logic [7:0] PROD_LOADING = 8'h01;
    localparam logic [7:0] PROD_SEALED = 8'h02;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLEEP_UNIT_NS = 10000;
    localparam int SLEEP_LIMIT_NS = SLEEP_UNIT_NS * (1 << SLEEP_TIME_CODE);
    localparam int SLEEP_LIMIT_CYC = SLEEP_LIMIT_NS / CLK_PERIOD_NS;
    localparam int POWEROFF_LIMIT_NS = 1000000;    // Plain default, not a device figure
    localparam int POWEROFF_LIMIT_CYC = POWEROFF_LIMIT_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Command kinds and core states
    // ----------------------------------------------------------------
    typedef enum logic {
        OP_READ = 1'b0,
        OP_SWITCH = 1'b1
    } op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_NOTICE = 1'b1
    } core_state_t;

endpackage

// ==== hw/ext_csd_link_port.sv ====
`timescale 1ns/1ps
// Link-side command capture; runs on the link clock
module ext_csd_link_port (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic cmd_op,
    input wire logic [ext_csd_pkg::IDX_W-1:0] cmd_index,
    input wire logic [7:0] cmd_value,
    input wire logic ack_tog,
    input wire logic [7:0] rsp_data,
    output logic req_tog,
    output logic op_hold,
    output logic [ext_csd_pkg::IDX_W-1:0] index_hold,
    output logic [7:0] value_hold,
    output logic busy,
    output logic done,
    output logic [7:0] data_out
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic req_q; // Request toggle toward the core
    logic busy_q; // Command outstanding
    logic done_q; // One-cycle answer pulse
    logic [7:0] data_q; // Last answer byte
    logic op_q;
    logic [ext_csd_pkg::IDX_W-1:0] index_q;
    logic [7:0] value_q;
    logic ack_s1_q; // First synchroniser stage, read only by ack_s2_q
    logic ack_s2_q;
    logic ack_s3_q; // Edge reference
    wire take = cmd_valid & ~busy_q; // Commands while busy are dropped
    wire ack_seen = ack_s2_q ^ ack_s3_q;

    // Ack toggle synchroniser
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tog;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // Capture; fields stay frozen until the core answers
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_q <= 1'b0;
            index_q <= '0;
            value_q <= 8'h00;
            req_q <= 1'b0;
        end else if (take) begin
            op_q <= cmd_op;
            index_q <= cmd_index;
            value_q <= cmd_value;
            req_q <= ~req_q;
        end
    end

    // Busy, answer pulse and answer data; data is stable in the core by the ack
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            busy_q <= take | (busy_q & ~ack_seen);
            done_q <= busy_q & ack_seen;
            if (busy_q && ack_seen) begin
                data_q <= rsp_data;
            end
        end
    end

    assign req_tog = req_q;
    assign op_hold = op_q;
    assign index_hold = index_q;
    assign value_hold = value_q;
    assign busy = busy_q;
    assign done = done_q;
    assign data_out = data_q;

endmodule

// ==== hw/ext_csd_fields.sv ====
`timescale 1ns/1ps
// Configuration fields: factory state, shutdown notice, sleep limit, purge type
module ext_csd_fields #(
    parameter int SLEEP_LIMIT_CYC = ext_csd_pkg::SLEEP_LIMIT_CYC,
    parameter int POWEROFF_LIMIT_CYC = ext_csd_pkg::POWEROFF_LIMIT_CYC
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic LINK_CLK,
    input wire logic CMD_VALID,
    input wire logic CMD_OP,
    input wire logic [ext_csd_pkg::IDX_W-1:0] CMD_INDEX,
    input wire logic [7:0] CMD_VALUE,
    input wire logic HPI,
    input wire logic PREP_DONE,
    output logic CMD_BUSY,
    output logic CMD_DONE,
    output logic [7:0] RD_DATA,
    output logic SLEEP_PENDING,
    output logic POWEROFF_PENDING,
    output logic AWARE_EN,
    output logic SEALED
);
    // ----------------------------------------------------------------
    // Link-side port
    // ----------------------------------------------------------------
    logic req_tog; // Request toggle from link domain
    logic op_hold; // Held command kind
    logic [ext_csd_pkg::IDX_W-1:0] index_hold; // Held field index
    logic [7:0] value_hold; // Held write value
    logic ack_tog_q; // Answer toggle back to link domain
    logic [7:0] rsp_data_q; // Answer byte, stable across the ack

    ext_csd_link_port u_link (
        .link_clk(LINK_CLK),
        .arst_n(ARST_N),
        .cmd_valid(CMD_VALID),
        .cmd_op(CMD_OP),
        .cmd_index(CMD_INDEX),
        .cmd_value(CMD_VALUE),
        .ack_tog(ack_tog_q),
        .rsp_data(rsp_data_q),
        .req_tog(req_tog),
        .op_hold(op_hold),
        .index_hold(index_hold),
        .value_hold(value_hold),
        .busy(CMD_BUSY),
        .done(CMD_DONE),
        .data_out(RD_DATA)
    );

    // ----------------------------------------------------------------
    // Synchronisers into the core clock
    // ----------------------------------------------------------------
    logic req_s1_q, req_s2_q, req_s3_q; // Request toggle stages
    logic hpi_s1_q, hpi_s2_q, hpi_s3_q; // Interrupt pin stages

    // Held fields are only read after the toggle has settled two stages
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            hpi_s1_q <= 1'b0;
            hpi_s2_q <= 1'b0;
            hpi_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tog;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            hpi_s1_q <= HPI;
            hpi_s2_q <= hpi_s1_q;
            hpi_s3_q <= hpi_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Field storage
    // ----------------------------------------------------------------
    logic [1:0] purge_sel_q; // Selected purge method
    logic [1:0] feat_en_q; // {mode, awareness enable}
    logic [7:0] notice_q; // Shutdown notice byte
    logic [7:0] prod_q; // Production state byte
    ext_csd_pkg::core_state_t state_q; // Notice wait or idle
    logic [31:0] cnt_q; // Cycles spent on a notice
    logic [31:0] limit_q; // Limit of the running notice

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire cmd_new = req_s2_q ^ req_s3_q;
    wire is_wr = cmd_new & (op_hold == ext_csd_pkg::OP_SWITCH);
    wire is_rd = cmd_new & (op_hold == ext_csd_pkg::OP_READ);
    wire wr_purge = is_wr & (index_hold == ext_csd_pkg::IDX_PURGE);
    wire wr_feat = is_wr & (index_hold == ext_csd_pkg::IDX_FEAT);
    wire wr_notice = is_wr & (index_hold == ext_csd_pkg::IDX_NOTICE);
    wire wr_prod = is_wr & (index_hold == ext_csd_pkg::IDX_PROD);
    wire [1:0] purge_wval = value_hold[ext_csd_pkg::PURGE_SEL_LSB +: 2];
    wire purge_ok = wr_purge & (purge_wval == ext_csd_pkg::PURGE_VENDOR);
    wire prod_ok = wr_prod & (value_hold <= ext_csd_pkg::PROD_SEALED);
    wire to_normal = prod_ok & (value_hold == ext_csd_pkg::PROD_NORMAL);
    wire note_sleep = wr_notice & (value_hold == ext_csd_pkg::NOTICE_SLEEP);
    wire note_off = wr_notice & (value_hold == ext_csd_pkg::NOTICE_POWER_OFF_LONG);
    wire note_start = (note_sleep | note_off) & (state_q == ext_csd_pkg::ST_IDLE);
    wire hpi_rise = hpi_s2_q & ~hpi_s3_q;
    wire time_up = (cnt_q + 32'h1) >= limit_q;
    // Interrupt, finished preparation or spent limit all end a notice
    wire note_end = (state_q == ext_csd_pkg::ST_NOTICE) & (hpi_rise | PREP_DONE | time_up);
    // Every non-notice command answers at once
    wire quick_ack = cmd_new & ~note_start;

    // Read mux; fixed capability bits always merged in
    wire [7:0] byte_purge = {2'h0, purge_sel_q, ext_csd_pkg::PURGE_CAPS};
    wire [7:0] byte_feat = {2'h0, feat_en_q, 2'h0, ext_csd_pkg::FEAT_CAPS};
    wire [7:0] rd_byte =
        (index_hold == ext_csd_pkg::IDX_PURGE) ? byte_purge :
        (index_hold == ext_csd_pkg::IDX_FEAT) ? byte_feat :
        (index_hold == ext_csd_pkg::IDX_NOTICE) ? notice_q :
        (index_hold == ext_csd_pkg::IDX_PROD) ? prod_q :
        (index_hold == ext_csd_pkg::IDX_SLEEP_T) ? ext_csd_pkg::SLEEP_TIME_CODE : 8'h00;

    // ----------------------------------------------------------------
    // Field writes
    // ----------------------------------------------------------------
    // Purge selection only moves to the vendor method; others are dropped
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            purge_sel_q <= ext_csd_pkg::PURGE_VENDOR;
        end else if (purge_ok) begin
            purge_sel_q <= purge_wval;
        end
    end

    // Return to normal wins over a same-cycle enable write
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            feat_en_q <= 2'h0;
        end else if (to_normal) begin
            feat_en_q <= 2'h0;
        end else if (wr_feat) begin
            feat_en_q <= {value_hold[ext_csd_pkg::FEAT_MODE_BIT], value_hold[ext_csd_pkg::FEAT_EN_BIT]};
        end
    end

    // Auto and reserved production codes never land
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prod_q <= ext_csd_pkg::PROD_NORMAL;
        end else if (prod_ok) begin
            prod_q <= value_hold;
        end
    end

    // Notice byte stores whatever the host writes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            notice_q <= ext_csd_pkg::NOTICE_RESET;
        end else if (wr_notice) begin
            notice_q <= value_hold;
        end
    end

    // ----------------------------------------------------------------
    // Notice sequencing
    // ----------------------------------------------------------------
    // The limit is latched at start so the counter compares one register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ext_csd_pkg::ST_IDLE;
            cnt_q <= 32'h0;
            limit_q <= 32'h1;
        end else begin
            case (state_q)
                ext_csd_pkg::ST_IDLE: begin
                    cnt_q <= 32'h0;
                    if (note_start) begin
                        state_q <= ext_csd_pkg::ST_NOTICE;
                        limit_q <= note_sleep ? 32'(SLEEP_LIMIT_CYC) : 32'(POWEROFF_LIMIT_CYC);
                    end
                end
                ext_csd_pkg::ST_NOTICE: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (note_end) begin
                        state_q <= ext_csd_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ext_csd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Answer path
    // ----------------------------------------------------------------
    // Data is set in the cycle the toggle flips, so the link sees it settled
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_tog_q <= 1'b0;
            rsp_data_q <= 8'h00;
        end else if (quick_ack | note_end) begin
            ack_tog_q <= ~ack_tog_q;
            rsp_data_q <= is_rd ? rd_byte : 8'h00;
        end
    end

    // Status outputs, all registered
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SLEEP_PENDING <= 1'b0;
            POWEROFF_PENDING <= 1'b0;
            AWARE_EN <= 1'b0;
            SEALED <= 1'b0;
        end else begin
            SLEEP_PENDING <= (state_q == ext_csd_pkg::ST_NOTICE) & (notice_q == ext_csd_pkg::NOTICE_SLEEP);
            POWEROFF_PENDING <= (state_q == ext_csd_pkg::ST_NOTICE) & (notice_q == ext_csd_pkg::NOTICE_POWER_OFF_LONG);
            AWARE_EN <= feat_en_q[0];
            SEALED <= (prod_q == ext_csd_pkg::PROD_SEALED);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_feat_caps_fixed: assert property (is_rd && index_hold == ext_csd_pkg::IDX_FEAT
        |=> rsp_data_q[1:0] == 2'b01)
        else $error("feature capability bits wrong");
    a_normal_clears_en: assert property (to_normal |=> feat_en_q == 2'h0 ##1 !AWARE_EN)
        else $error("return to normal left enables set");
    a_hpi_ends_notice: assert property ((state_q == ext_csd_pkg::ST_NOTICE) && hpi_rise
        |=> state_q == ext_csd_pkg::ST_IDLE && $changed(ack_tog_q))
        else $error("interrupt did not end notice");
    a_sleep_code_ro: assert property (is_rd && index_hold == ext_csd_pkg::IDX_SLEEP_T
        |=> rsp_data_q == 8'h0e)
        else $error("sleep limit byte not 0x0e");
    a_notice_bounded: assert property ((state_q == ext_csd_pkg::ST_NOTICE) |-> cnt_q < limit_q)
        else $error("notice ran past its limit");
    a_sleep_start: assert property (note_sleep && state_q == ext_csd_pkg::ST_IDLE
        |=> limit_q == 32'(SLEEP_LIMIT_CYC) ##1 SLEEP_PENDING || state_q == ext_csd_pkg::ST_IDLE)
        else $error("sleep notice not started");
    a_off_start: assert property (note_off && state_q == ext_csd_pkg::ST_IDLE
        |=> state_q == ext_csd_pkg::ST_NOTICE && limit_q == 32'(POWEROFF_LIMIT_CYC))
        else $error("power-off notice not started");
    a_purge_vendor: assert property (purge_sel_q == 2'h3)
        else $error("purge selection left vendor method");
    a_purge_caps: assert property (is_rd && index_hold == ext_csd_pkg::IDX_PURGE
        |=> rsp_data_q[3:0] == 4'h8)
        else $error("purge capability bits wrong");
    a_prod_no_auto: assert property (wr_prod && value_hold > 8'h02 |=> $stable(prod_q))
        else $error("refused production code was stored");
    a_read_answer: assert property (is_rd |=> $changed(ack_tog_q) && rsp_data_q == $past(rd_byte))
        else $error("read answer missing or wrong");

    c_sleep_done: cover property (SLEEP_PENDING ##1 !SLEEP_PENDING);
    c_off_hpi: cover property (state_q == ext_csd_pkg::ST_NOTICE && hpi_rise);
    c_normal_clear: cover property (feat_en_q != 2'h0 ##1 to_normal);
    c_read_feat: cover property (is_rd && index_hold == ext_csd_pkg::IDX_FEAT);

endmodule

// ==== dv/ext_csd_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host link model: one command outstanding, high-priority interrupt
// ----------------------------------------------------------------
module ext_csd_host_model (
    input wire logic LINK_CLK,
    input wire logic ARST_N,
    input wire logic CMD_BUSY,
    input wire logic CMD_DONE,
    output logic CMD_VALID,
    output logic CMD_OP,
    output logic [ext_csd_pkg::IDX_W-1:0] CMD_INDEX,
    output logic [7:0] CMD_VALUE,
    output logic HPI
);
    // Idle levels at time zero
    initial begin
        CMD_VALID = 1'b0;
        CMD_OP = 1'b0;
        CMD_INDEX = '0;
        CMD_VALUE = 8'h00;
        HPI = 1'b0;
    end

    // One command; released lines show the inverse so stale values never look valid
    task automatic issue(input logic op, input logic [ext_csd_pkg::IDX_W-1:0] idx, input logic [7:0] val);
        int n;
        n = 0;
        // Always launch just after a link edge, never in the edge's own time step
        @(posedge LINK_CLK);
        #1;
        while ((ARST_N !== 1'b1 || CMD_BUSY !== 1'b0) && n < 100) begin
            @(posedge LINK_CLK);
            #1;
            n++;
        end
        CMD_VALID = 1'b1;
        CMD_OP = op;
        CMD_INDEX = idx;
        CMD_VALUE = val;
        @(posedge LINK_CLK);
        #1;
        CMD_VALID = 1'b0;
        CMD_OP = ~op;
        CMD_INDEX = ~idx;
        CMD_VALUE = ~val;
        // Bounded wait; the bench watchdog catches a hang beyond it
        n = 0;
        while (CMD_DONE !== 1'b1 && n < 5000) begin
            @(posedge LINK_CLK);
            #1;
            n++;
        end
    endtask

    // Sleep notice ahead of removing the core supply
    task automatic sleep_notice();
        issue(ext_csd_pkg::OP_SWITCH, ext_csd_pkg::IDX_NOTICE, ext_csd_pkg::NOTICE_SLEEP);
    endtask

    // Short high-priority interrupt pulse, rising edge aborts a notice
    task automatic hpi_pulse();
        @(posedge LINK_CLK);
        #1;
        HPI = 1'b1;
        repeat (3) @(posedge LINK_CLK);
        #1;
        HPI = 1'b0;
    endtask
endmodule

// ==== dv/ext_csd_fields_bench.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench: queued expectations, answers compared at each CMD_DONE
// ----------------------------------------------------------------
module ext_csd_fields_bench;
    localparam int SLEEP_LIM = 200; // Shortened limits keep the run brief
    localparam int PO_LIM = 100;
    logic clk, link_clk, arst_n, prep_done;
    logic cmd_valid, cmd_op, hpi, cmd_busy, cmd_done, sleep_pending, poweroff_pending, aware_en, sealed;
    logic [ext_csd_pkg::IDX_W-1:0] cmd_index;
    logic [7:0] cmd_value, rd_data, v;
    logic [7:0] expq[$]; // Expected answer bytes in issue order
    int miscompares, checked, seed, k, n, lim;
    time t0;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Link clock, six core periods long, at a fixed phase offset from the core clock
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #24 link_clk = ~link_clk;
    end

    ext_csd_fields #(.SLEEP_LIMIT_CYC(SLEEP_LIM), .POWEROFF_LIMIT_CYC(PO_LIM)) dut_u (
        .CLK(clk), .ARST_N(arst_n), .LINK_CLK(link_clk), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_INDEX(cmd_index), .CMD_VALUE(cmd_value), .HPI(hpi), .PREP_DONE(prep_done),
        .CMD_BUSY(cmd_busy), .CMD_DONE(cmd_done), .RD_DATA(rd_data), .SLEEP_PENDING(sleep_pending),
        .POWEROFF_PENDING(poweroff_pending), .AWARE_EN(aware_en), .SEALED(sealed));
    ext_csd_host_model host_u (
        .LINK_CLK(link_clk), .ARST_N(arst_n), .CMD_BUSY(cmd_busy), .CMD_DONE(cmd_done),
        .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_INDEX(cmd_index), .CMD_VALUE(cmd_value), .HPI(hpi));

    // ----------------------------------------------------------------
    // Shared comparison and command tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic op, input logic [ext_csd_pkg::IDX_W-1:0] idx, input logic [7:0] val,
                       input logic [7:0] exp);
        expq.push_back(exp);
        host_u.issue(op, idx, val);
    endtask
    task automatic rd(input logic [ext_csd_pkg::IDX_W-1:0] idx, input logic [7:0] exp);
        cmd(ext_csd_pkg::OP_READ, idx, 8'h00, exp);
    endtask
    task automatic wr(input logic [ext_csd_pkg::IDX_W-1:0] idx, input logic [7:0] val);
        cmd(ext_csd_pkg::OP_SWITCH, idx, val, 8'h00); // Writes answer with zero
    endtask
    // Core-domain flag, sampled after the edge has settled
    task automatic flag(input logic got, input logic exp);
        @(posedge clk);
        #1;
        check({7'h00, got}, {7'h00, exp});
    endtask

    // Answer monitor: RD_DATA stands the whole cycle of CMD_DONE; busy has already dropped
    always @(negedge link_clk) begin
        if (cmd_done === 1'b1) begin
            check({7'h00, cmd_busy}, 8'h00);
            // An answer nobody asked for counts as a mismatch, even with unknown data
            if (expq.size() == 0) check({7'h00, cmd_done}, 8'h00);
            else check(rd_data, expq.pop_front());
        end
    end

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog sized well above the expected run
    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 88280;
        arst_n = 1'b0;
        prep_done = 1'b0;
        repeat (8) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (2) @(posedge link_clk);
        rd(ext_csd_pkg::IDX_PURGE, 8'h38);
        rd(ext_csd_pkg::IDX_FEAT, 8'h01);
        rd(ext_csd_pkg::IDX_NOTICE, 8'h00);
        rd(ext_csd_pkg::IDX_SLEEP_T, 8'h0e);
        rd(9'h1ff, 8'h00);
        wr(ext_csd_pkg::IDX_SLEEP_T, 8'h17);
        rd(ext_csd_pkg::IDX_SLEEP_T, 8'h0e);
        // Only mode and enable are writable; capability bits stay fixed
        wr(ext_csd_pkg::IDX_FEAT, 8'hff);
        rd(ext_csd_pkg::IDX_FEAT, 8'h31);
        flag(aware_en, 1'b1);
        for (k = 1; k <= 3; k++) begin
            wr(ext_csd_pkg::IDX_PROD, k[7:0]);
            rd(ext_csd_pkg::IDX_PROD, (k == 3) ? 8'h02 : k[7:0]);
        end
        flag(sealed, 1'b1);
        wr(ext_csd_pkg::IDX_PROD, ext_csd_pkg::PROD_NORMAL);
        rd(ext_csd_pkg::IDX_FEAT, 8'h01);
        flag(aware_en, 1'b0);
        flag(sealed, 1'b0);
        // Unsupported purge methods refused, vendor method kept
        for (k = 0; k < 4; k++) begin
            v = 8'(($random(seed) & 8'hcf) | (k[7:0] << 4));
            wr(ext_csd_pkg::IDX_PURGE, v);
            rd(ext_csd_pkg::IDX_PURGE, 8'h38);
        end
        // Notices: k=0 sleep ended early, k=1 power-off aborted by HPI, k=2,3 run to limit
        for (k = 0; k < 4; k++) begin
            v = k[0] ? ext_csd_pkg::NOTICE_POWER_OFF_LONG : ext_csd_pkg::NOTICE_SLEEP;
            lim = k[0] ? PO_LIM : SLEEP_LIM;
            t0 = $time;
            fork
                if (k == 0) begin
                    expq.push_back(8'h00);
                    host_u.sleep_notice();
                end else begin
                    wr(ext_csd_pkg::IDX_NOTICE, v);
                end
                begin
                    n = 0;
                    while ((k[0] ? poweroff_pending : sleep_pending) !== 1'b1 && n < 60) begin
                        @(posedge clk);
                        #1;
                        n++;
                    end
                    check({7'h00, k[0] ? poweroff_pending : sleep_pending}, 8'h01);
                    if (k == 0) begin
                        @(posedge clk);
                        #1 prep_done = 1'b1;
                        @(posedge clk);
                        #1 prep_done = 1'b0;
                    end else if (k == 1) begin
                        host_u.hpi_pulse();
                    end
                end
            join
            if (k < 2) check({7'h00, ($time - t0) < lim * 8}, 8'h01);
            else check({7'h00, ($time - t0) >= (lim - 4) * 8 && ($time - t0) <= (lim + 60) * 8}, 8'h01);
            flag(k[0] ? poweroff_pending : sleep_pending, 1'b0);
            rd(ext_csd_pkg::IDX_NOTICE, v);
        end
        repeat (4) @(posedge link_clk);
        // A lost answer leaves a note behind; that must not pass
        check(8'(expq.size()), 8'h00);
        give_verdict();
    end
endmodule
